// >>> scpl_top.sv
// System control pin logic: reset pin, E clock, interrupt pins, modes.
`timescale 1ns/1ns
`include "scpl_regs.svh"
module scpl_top #(
    parameter int DRIVE_ECYC = `SCPL_DRIVE_ECYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe_n,
    input wire logic clock_monitor_fail,
    input wire logic watchdog_timer_fail,
    output logic cpu_reset_n,
    output logic e_clock_out,
    output logic e_clock_oe_n,
    output logic e_tick,
    output logic buffered_clock_out,
    input wire logic irq_pin_n,
    input wire logic irq_ack,
    output logic irq_request,
    input wire logic nonmaskable_irq_pin_n,
    output logic nmi_request,
    input wire logic mode_select_a_pin,
    input wire logic mode_select_b_pin,
    input wire logic cpu_opcode_fetch,
    output logic instruction_fetch_indicator,
    output logic fetch_ind_oe_n
);
    default clocking cb_aclk @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // *******************************************************
    // Register bus
    // *******************************************************
    logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
    logic [3:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic wstb_r, wstb_nxt, wr_en;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [`SCPL_CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic [7:0] stat_w;

    function automatic logic [1:0] reg_sel(input logic [3:0] a);
        case (a)
            `SCPL_CTRL_OFS: reg_sel = 2'h1;
            `SCPL_STAT_OFS: reg_sel = 2'h2;
            default: reg_sel = 2'h0;
        endcase
    endfunction : reg_sel

    assign s_axi_awready = !aw_full_r;
    assign s_axi_wready = !w_full_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign wr_en = aw_full_r && w_full_r && !bvalid_r;

    always_comb begin
        aw_full_nxt = aw_full_r;
        awaddr_nxt = awaddr_r;
        w_full_nxt = w_full_r;
        wdata_nxt = wdata_r;
        wstb_nxt = wstb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (s_axi_awvalid && !aw_full_r) begin
            aw_full_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_full_r) begin
            w_full_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstb_nxt = s_axi_wstrb[0];
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (wr_en) begin
            aw_full_nxt = 1'b0;
            w_full_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = (reg_sel(awaddr_r) == 2'h0) ?
                `SCPL_AXI_SLVERR : `SCPL_AXI_OKAY;
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = `SCPL_AXI_OKAY;
            case (reg_sel(s_axi_araddr))
                2'h1: rdata_nxt = {25'h0, ctrl_r};
                2'h2: rdata_nxt = {24'h0, stat_w};
                default: begin
                    rdata_nxt = 32'h0;
                    rresp_nxt = `SCPL_AXI_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            awaddr_r <= 4'h0;
            w_full_r <= 1'b0;
            wdata_r <= 32'h0;
            wstb_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
            rvalid_r <= 1'b0;
            rresp_r <= 2'h0;
            rdata_r <= 32'h0;
        end else begin
            aw_full_r <= aw_full_nxt;
            awaddr_r <= awaddr_nxt;
            w_full_r <= w_full_nxt;
            wdata_r <= wdata_nxt;
            wstb_r <= wstb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // *******************************************************
    // Reset pin sequencer and mode latch
    // *******************************************************
    scpl_pkg::scpl_state_t st_r, st_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic ext_r, ext_nxt;
    scpl_pkg::scpl_mode_t mode_r, mode_nxt;
    logic [1:0] phase_r, phase_nxt;
    logic running, leave_rst, fault, exp_mode, single_mode;

    assign running = (st_r == scpl_pkg::SCPL_ST_RUN);
    assign fault = clock_monitor_fail || watchdog_timer_fail;
    assign leave_rst = (st_r == scpl_pkg::SCPL_ST_WAIT) && reset_pin_in;
    assign cpu_reset_n = running;
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe_n = (st_r != scpl_pkg::SCPL_ST_DRIVE);
    assign exp_mode = mode_r[0];
    assign single_mode = !mode_r[0];

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        ext_nxt = ext_r;
        mode_nxt = mode_r;
        case (st_r)
            scpl_pkg::SCPL_ST_RUN: begin
                if (fault || !reset_pin_in) begin
                    st_nxt = scpl_pkg::SCPL_ST_DRIVE;
                    cnt_nxt = 4'h0;
                end
            end
            scpl_pkg::SCPL_ST_DRIVE: begin
                if (e_tick) begin
                    cnt_nxt = cnt_r + 4'h1;
                    if (cnt_r == 4'(DRIVE_ECYC - 1)) begin
                        st_nxt = scpl_pkg::SCPL_ST_WAIT;
                        cnt_nxt = 4'h0;
                    end
                end
            end
            scpl_pkg::SCPL_ST_WAIT: begin
                if (reset_pin_in) begin
                    st_nxt = scpl_pkg::SCPL_ST_RUN;
                    ext_nxt = (cnt_r >= 4'(`SCPL_EXT_THRESH));
                    mode_nxt = scpl_pkg::scpl_mode_t'(
                        {mode_select_b_pin, mode_select_a_pin});
                end else if (e_tick && cnt_r != 4'hF) begin
                    cnt_nxt = cnt_r + 4'h1;
                end
            end
            default: st_nxt = scpl_pkg::SCPL_ST_DRIVE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= scpl_pkg::SCPL_ST_DRIVE;
            cnt_r <= 4'h0;
            ext_r <= 1'b0;
            mode_r <= scpl_pkg::SCPL_MODE_SINGLE;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            ext_r <= ext_nxt;
            mode_r <= mode_nxt;
        end
    end
    a_kind_ext: assert property (leave_rst && cnt_r > 4'h2 |=> ext_r)
        else $error("long reset not taken as external");
    a_kind_int: assert property (leave_rst && cnt_r < 4'h2 |=> !ext_r)
        else $error("short reset not taken as internal");
    a_fault_drive: assert property (running && fault
        |=> !reset_pin_oe_n && !cpu_reset_n)
        else $error("fault did not pull reset pin low");
    a_mode_hold: assert property (running && $past(running)
        |-> $stable(mode_r))
        else $error("mode changed outside reset");

    // *******************************************************
    // Control bits, interrupts and stop
    // *******************************************************
    logic irq_prev_r, irq_prev_nxt, irq_edge_r, irq_edge_nxt;
    logic irq_pend, stop_r;
    logic [7:0] wb;

    assign wb = wdata_r[7:0];
    assign stop_r = ctrl_r[`SCPL_C_STOP];
    assign irq_pend = ctrl_r[`SCPL_C_EDGE] ? irq_edge_r : !irq_pin_n;
    assign irq_request = running && irq_pend
        && !ctrl_r[`SCPL_C_IMSK];
    assign nmi_request = running && !nonmaskable_irq_pin_n
        && !ctrl_r[`SCPL_C_XMSK];
    assign stat_w = {running, stop_r, nmi_request, irq_pend,
        ctrl_r[`SCPL_C_XMSK], ext_r, mode_r};

    always_comb begin
        ctrl_nxt = ctrl_r;
        irq_prev_nxt = irq_pin_n;
        irq_edge_nxt = irq_edge_r;
        if (irq_ack) begin
            irq_edge_nxt = 1'b0;
        end
        if (irq_prev_r && !irq_pin_n) begin
            irq_edge_nxt = 1'b1;
        end
        if (irq_request || nmi_request) begin
            ctrl_nxt[`SCPL_C_STOP] = 1'b0;
        end
        if (wr_en && wstb_r && reg_sel(awaddr_r) == 2'h1) begin
            ctrl_nxt[`SCPL_C_XMSK-1:0] = wb[`SCPL_C_XMSK-1:0];
            ctrl_nxt[`SCPL_C_XMSK] = ctrl_r[`SCPL_C_XMSK]
                && wb[`SCPL_C_XMSK];
        end
        if (!running) begin
            ctrl_nxt = 7'h0;
            ctrl_nxt[`SCPL_C_IMSK] = 1'b1;
            ctrl_nxt[`SCPL_C_XMSK] = 1'b1;
            irq_edge_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= 7'h60;
            irq_prev_r <= 1'b1;
            irq_edge_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            irq_prev_r <= irq_prev_nxt;
            irq_edge_r <= irq_edge_nxt;
        end
    end
    a_irq_mask: assert property (ctrl_r[`SCPL_C_IMSK] |-> !irq_request)
        else $error("masked interrupt pin passed through");
    a_irq_again: assert property (running && !ctrl_r[`SCPL_C_EDGE]
        && !irq_pin_n && !ctrl_r[`SCPL_C_IMSK] |-> irq_request)
        else $error("low level line not requesting");
    a_x_set_out: assert property (leave_rst |=> ctrl_r[`SCPL_C_XMSK])
        else $error("X mask not set leaving reset");
    a_x_oneway: assert property (running && !ctrl_r[`SCPL_C_XMSK]
        ##1 running |-> !ctrl_r[`SCPL_C_XMSK])
        else $error("X mask set again by software");
    a_nmi_level: assert property (nmi_request
        |-> !nonmaskable_irq_pin_n)
        else $error("non-maskable request without low level");

    // *******************************************************
    // E clock, buffered clock and fetch indicator
    // *******************************************************
    logic e_out_r, e_out_nxt, e_oe_n_r, e_oe_n_nxt;
    logic xo_r, xo_nxt, fetch_r, fetch_nxt;
    logic li_out_r, li_out_nxt, li_oe_n_r, li_oe_n_nxt;

    assign e_tick = running ? (!stop_r && phase_r == 2'h3)
        : (phase_r == 2'h3);
    assign e_clock_out = e_out_r;
    assign e_clock_oe_n = e_oe_n_r;
    assign buffered_clock_out = xo_r;
    assign instruction_fetch_indicator = li_out_r;
    assign fetch_ind_oe_n = li_oe_n_r;

    always_comb begin
        phase_nxt = phase_r;
        fetch_nxt = fetch_r;
        if (!running || !stop_r) begin
            phase_nxt = phase_r + 2'h1;
        end
        if (e_tick) begin
            fetch_nxt = running && cpu_opcode_fetch;
        end
        e_out_nxt = phase_nxt[1];
        e_oe_n_nxt = single_mode && ctrl_r[`SCPL_C_EOFF];
        xo_nxt = ctrl_r[`SCPL_C_BUFCLK] && phase_nxt[0];
        li_out_nxt = 1'b0;
        li_oe_n_nxt = 1'b1;
        if (running && exp_mode) begin
            if (fetch_nxt) begin
                li_oe_n_nxt = 1'b0;
            end else if (ctrl_r[`SCPL_C_LDRV] && phase_nxt == 2'h0
                && phase_nxt != phase_r) begin
                li_out_nxt = 1'b1;
                li_oe_n_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_r <= 2'h0;
            fetch_r <= 1'b0;
            e_out_r <= 1'b0;
            e_oe_n_r <= 1'b0;
            xo_r <= 1'b0;
            li_out_r <= 1'b0;
            li_oe_n_r <= 1'b1;
        end else begin
            phase_r <= phase_nxt;
            fetch_r <= fetch_nxt;
            e_out_r <= e_out_nxt;
            e_oe_n_r <= e_oe_n_nxt;
            xo_r <= xo_nxt;
            li_out_r <= li_out_nxt;
            li_oe_n_r <= li_oe_n_nxt;
        end
    end
    a_e_period: assert property ($rose(e_out_r) && !stop_r
        ##1 (!stop_r && running) [*3] |=> $rose(e_out_r))
        else $error("E clock period not four oscillator cycles");
    a_e_halt: assert property (running && stop_r && $past(stop_r)
        |-> $stable(e_out_r) && $stable(phase_r))
        else $error("E clock moved in stop mode");
    a_e_off: assert property (single_mode && ctrl_r[`SCPL_C_EOFF]
        |=> e_oe_n_r)
        else $error("E pin driven while switched off");
    a_fetch_low: assert property (running && exp_mode && fetch_r
        |-> !li_oe_n_r && !li_out_r)
        else $error("fetch indicator not low in fetch cycle");
    a_fetch_nohi: assert property (!ctrl_r[`SCPL_C_LDRV]
        |=> !(li_out_r && !li_oe_n_r))
        else $error("fetch indicator driven high without option");

endmodule : scpl_top

// >>> scpl_regs.svh
// Register offsets, field positions and counts.
`ifndef SCPL_REGS_SVH
`define SCPL_REGS_SVH

// ***********************************************************
// Register map
// ***********************************************************
`define SCPL_CTRL_OFS 4'h0
`define SCPL_STAT_OFS 4'h4
`define SCPL_AXI_OKAY 2'h0
`define SCPL_AXI_SLVERR 2'h2

// ***********************************************************
// Control register fields
// ***********************************************************
`define SCPL_C_EOFF 0
`define SCPL_C_BUFCLK 1
`define SCPL_C_EDGE 2
`define SCPL_C_LDRV 3
`define SCPL_C_STOP 4
`define SCPL_C_IMSK 5
`define SCPL_C_XMSK 6
`define SCPL_CTRL_W 7

// ***********************************************************
// Status register fields
// ***********************************************************
`define SCPL_S_MODE 0
`define SCPL_S_EXT 2
`define SCPL_S_XMSK 3
`define SCPL_S_IPEND 4
`define SCPL_S_XREQ 5
`define SCPL_S_STOP 6
`define SCPL_S_RUN 7

// ***********************************************************
// Timing
// ***********************************************************
`define SCPL_OSC_PER_E 4
`define SCPL_EXT_THRESH 2'h2
`define SCPL_DRIVE_ECYC 4
`endif

// >>> scpl_pkg.sv
// Types shared by the system control pin logic.
package scpl_pkg;

    typedef enum logic [2:0] {
        SCPL_ST_RUN = 3'b001,
        SCPL_ST_DRIVE = 3'b010,
        SCPL_ST_WAIT = 3'b100
    } scpl_state_t;

    // Mode codes are the two mode pin levels, b pin in the upper bit.
    typedef enum logic [1:0] {
        SCPL_MODE_BOOT = 2'h0,
        SCPL_MODE_TEST = 2'h1,
        SCPL_MODE_SINGLE = 2'h2,
        SCPL_MODE_EXPANDED = 2'h3
    } scpl_mode_t;

endpackage : scpl_pkg

// >>> scpl_partner.sv
// Far-side model: external reset source and shared interrupt sources.
`timescale 1ns/1ns
module scpl_partner (
    input wire logic aclk,
    input wire logic hold_reset,
    input wire logic raise_irq,
    input wire logic irq_ack,
    output logic reset_drive_low,
    output logic irq_line_n
);
    logic [3:0] pend_r = 4'h0;
    logic [3:0] pend_nxt;
    logic dec;

    // Each source holds the pulled-up line low until it is acknowledged.
    always_comb begin
        dec = irq_ack && (pend_r != 4'h0);
        pend_nxt = pend_r + {3'h0, raise_irq} - {3'h0, dec};
    end
    always_ff @(posedge aclk) begin
        pend_r <= pend_nxt;
    end
    assign irq_line_n = (pend_r == 4'h0);
    assign reset_drive_low = hold_reset;
endmodule : scpl_partner

// >>> scpl_tb_top.sv
// Self-checking testbench of the system control pin logic.
`timescale 1ns/1ns
`include "scpl_regs.svh"
module scpl_tb_top;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, reset_pin_out;
    logic reset_pin_oe_n, clock_monitor_fail, watchdog_timer_fail;
    logic cpu_reset_n, e_clock_out, e_clock_oe_n, e_tick, irq_ack;
    logic buffered_clock_out, irq_request, nonmaskable_irq_pin_n;
    logic nmi_request, mode_select_a_pin, mode_select_b_pin;
    logic cpu_opcode_fetch, instruction_fetch_indicator, fetch_ind_oe_n;
    logic hold_reset, raise_irq, reset_drive_low, irq_line_n, rst_wire;
    int failures, n_tests, cyc, c_rise, c_tick, c_buf, c_hi, c_lo;

    // The reset pin is open drain with a pull-up on the board.
    assign rst_wire = !((!reset_pin_oe_n && !reset_pin_out) ||
        reset_drive_low);

    scpl_top #(.DRIVE_ECYC(2)) dut_u (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .reset_pin_in(rst_wire),
        .reset_pin_out, .reset_pin_oe_n, .clock_monitor_fail,
        .watchdog_timer_fail, .cpu_reset_n, .e_clock_out, .e_clock_oe_n,
        .e_tick, .buffered_clock_out, .irq_pin_n(irq_line_n), .irq_ack,
        .irq_request, .nonmaskable_irq_pin_n, .nmi_request,
        .mode_select_a_pin, .mode_select_b_pin, .cpu_opcode_fetch,
        .instruction_fetch_indicator, .fetch_ind_oe_n
    );
    scpl_partner partner_u (.aclk, .hold_reset, .raise_irq, .irq_ack,
        .reset_drive_low, .irq_line_n);

    initial begin
        aclk = 1'h0;
        forever #4 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            final_report();
        end
    end

    // ***********************************************************
    // Shared tasks
    // ***********************************************************
    task automatic final_report;
        $display("checks %0d errors %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic ad = 1'h0;
        logic wd = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (s_axi_awready && !ad) begin
                ad = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (s_axi_wready && !wd) begin
                wd = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [3:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask : rd

    task automatic wait_run;
        while (cpu_reset_n !== 1'h1) @(posedge aclk);
        @(posedge aclk);
    endtask : wait_run

    task automatic pulse(input int which);
        if (which == 0) raise_irq <= 1'h1;
        else irq_ack <= 1'h1;
        @(posedge aclk);
        raise_irq <= 1'h0;
        irq_ack <= 1'h0;
        repeat (3) @(posedge aclk);
    endtask : pulse

    // Counts clock and indicator events over four E cycles.
    task automatic sample16;
        logic pe = e_clock_out;
        logic pb = buffered_clock_out;
        {c_rise, c_tick, c_buf, c_hi, c_lo} = '0;
        repeat (16) begin
            @(posedge aclk);
            c_rise += int'(e_clock_out && !pe);
            c_tick += int'(e_tick && e_clock_out);
            c_buf += int'(buffered_clock_out != pb);
            c_hi += int'(!fetch_ind_oe_n && instruction_fetch_indicator);
            c_lo += int'(!fetch_ind_oe_n && !instruction_fetch_indicator);
            pe = e_clock_out;
            pb = buffered_clock_out;
        end
    endtask : sample16

    // ***********************************************************
    // Scenarios
    // ***********************************************************
    task automatic t_start;
        wait_run();
        rd(`SCPL_CTRL_OFS);
        chk("ctrl reset", 32'h60, rdat);
        rd(`SCPL_STAT_OFS);
        chk("stat reset", 32'h8B, rdat);
    endtask : t_start

    task automatic t_eclk;
        wr(`SCPL_CTRL_OFS, 32'h62);
        sample16();
        chk("e rises", 32'h4, c_rise);
        chk("tick in high", 32'h4, c_tick);
        chk("bufclk toggles", 32'h10, c_buf);
        wr(`SCPL_CTRL_OFS, 32'h50);
        repeat (4) @(posedge aclk);
        sample16();
        chk("e stopped", 32'h0, c_rise + c_buf);
        pulse(0);
        sample16();
        chk("e resumed", 32'h4, c_rise);
        pulse(1);
        wr(`SCPL_CTRL_OFS, 32'h60);
    endtask : t_eclk

    task automatic t_irq;
        pulse(0);
        pulse(0);
        chk("irq masked", 32'h0, irq_request);
        wr(`SCPL_CTRL_OFS, 32'h40);
        chk("irq level", 32'h1, irq_request);
        pulse(1);
        chk("irq line held", 32'h1, irq_request);
        wr(`SCPL_CTRL_OFS, 32'h60);
        chk("irq remasked", 32'h0, irq_request);
        wr(`SCPL_CTRL_OFS, 32'h40);
        chk("irq again", 32'h1, irq_request);
        pulse(1);
        wr(`SCPL_CTRL_OFS, 32'h44);
        pulse(0);
        pulse(0);
        chk("irq edge", 32'h1, irq_request);
        pulse(1);
        chk("irq edge cleared", 32'h0, irq_request);
        pulse(1);
        wr(`SCPL_CTRL_OFS, 32'h60);
    endtask : t_irq

    task automatic t_nmi;
        nonmaskable_irq_pin_n <= 1'h0;
        repeat (3) @(posedge aclk);
        chk("nmi masked", 32'h0, nmi_request);
        wr(`SCPL_CTRL_OFS, 32'h20);
        chk("nmi taken", 32'h1, nmi_request);
        wr(`SCPL_CTRL_OFS, 32'h60);
        rd(`SCPL_STAT_OFS);
        chk("nmi mask sticky", 32'h0, rdat[3]);
        chk("nmi unmaskable", 32'h1, nmi_request);
        nonmaskable_irq_pin_n <= 1'h1;
        repeat (3) @(posedge aclk);
        chk("nmi level", 32'h0, nmi_request);
    endtask : t_nmi

    task automatic t_fault;
        for (int i = 0; i < 2; i++) begin
            watchdog_timer_fail <= (i == 0);
            clock_monitor_fail <= (i == 1);
            @(posedge aclk);
            {watchdog_timer_fail, clock_monitor_fail} <= 2'h0;
            repeat (3) @(posedge aclk);
            chk("pin driven", 32'h0, {reset_pin_oe_n, reset_pin_out});
            chk("cpu held", 32'h0, cpu_reset_n);
            wait_run();
            rd(`SCPL_STAT_OFS);
            chk("internal", 32'h0, rdat[2]);
        end
    endtask : t_fault

    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            hold_reset <= 1'h1;
            {mode_select_b_pin, mode_select_a_pin} <= m[1:0];
            repeat (40) @(posedge aclk);
            hold_reset <= 1'h0;
            wait_run();
            {mode_select_b_pin, mode_select_a_pin} <= ~m[1:0];
            rd(`SCPL_STAT_OFS);
            chk("mode", m[1:0], rdat[1:0]);
            chk("external", 32'h1, rdat[2]);
            wr(`SCPL_CTRL_OFS, 32'h61);
            repeat (2) @(posedge aclk);
            chk("e driver off", !m[0], e_clock_oe_n);
            cpu_opcode_fetch <= 1'h1;
            sample16();
            cpu_opcode_fetch <= 1'h0;
            chk("fetch ind", m[0], c_lo != 0);
        end
    endtask : t_modes

    task automatic t_ldrv;
        wr(`SCPL_CTRL_OFS, 32'h68);
        chk("bresp ok", {30'h0, `SCPL_AXI_OKAY}, {30'h0, resp});
        sample16();
        chk("drive high", 32'h4, c_hi);
        wr(`SCPL_CTRL_OFS, 32'h60);
        sample16();
        chk("no drive high", 32'h0, c_hi);
        rd(4'h8);
        chk("unmapped", {30'h0, `SCPL_AXI_SLVERR}, {rdat[29:0], resp});
        wr(4'h8, 32'h7F);
        chk("bresp unmapped", {30'h0, `SCPL_AXI_SLVERR}, {30'h0, resp});
        rd(`SCPL_CTRL_OFS);
        chk("unmapped write ignored", 32'h60, rdat);
    endtask : t_ldrv

    initial begin
        {failures, n_tests, cyc} = '0;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, clock_monitor_fail, watchdog_timer_fail} = '0;
        {irq_ack, cpu_opcode_fetch, hold_reset, raise_irq} = '0;
        s_axi_wstrb = 4'hF;
        nonmaskable_irq_pin_n = 1'h1;
        mode_select_a_pin = 1'h1;
        mode_select_b_pin = 1'h1;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        t_start();
        t_eclk();
        t_irq();
        t_nmi();
        t_fault();
        t_modes();
        t_ldrv();
        final_report();
    end
endmodule : scpl_tb_top
